// ===== ffl_fault_latch.sv
// fault supervision and latching logic of the flash driver
`default_nettype none

module ffl_fault_latch #(
  parameter int TICK_CYCLES   = ffl_pkg::TICK_CYCLES,
  parameter int TIMEOUT_TICKS = ffl_pkg::TIMEOUT_TICKS
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       supply_low_lockout,
  input  wire logic       register_mode,
  input  wire logic       enable_input_one,
  input  wire logic       enable_input_two,
  input  wire logic       torch_input,
  input  wire logic       strobe_input,
  input  wire logic       ovp_trip,
  input  wire logic       cap_missing,
  input  wire logic       thermal_trip,
  input  wire logic       lamp_short,
  input  wire logic       ilim_trip,
  input  wire logic       vf_high,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            driver_enable,
  output logic            event_active,
  output logic            detect_drive,
  output logic      [1:0] ilim_select
);
  import ffl_pkg::*;

  // any latched fault holds the driver off; bit 3 is status only
  function automatic logic has_fault(input logic [7:0] flags);
    return |(flags & FLAG_LATCH_MASK);
  endfunction : has_fault

  // reserved bits and unmapped addresses read as zero
  function automatic logic [7:0] read_view(input logic [7:0] addr,
                                           input logic [7:0] mode,
                                           input logic [7:0] flags);
    logic [7:0] view;
    view = 8'h00;
    unique case (addr)
      ADDR_OUTPUT_MODE_CONTROL: view = mode;
      ADDR_FAULT_FLAGS:         view = flags & FLAG_READ_MASK;
      default:                  view = 8'h00;
    endcase
    return view;
  endfunction : read_view

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic             s_supply_low_lockout;
  logic             s_en1;
  logic             s_en2;
  logic             s_torch;
  logic             s_strobe;
  logic             s_ovp;
  logic             s_cap;
  logic             s_therm;
  logic             s_short;
  logic             s_ilim;
  logic             s_vf;

  assign raw_in = {
    supply_low_lockout,
    enable_input_one,
    enable_input_two,
    torch_input,
    strobe_input,
    ovp_trip,
    cap_missing,
    thermal_trip,
    lamp_short,
    ilim_trip,
    vf_high
  };

  // the first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in; // R14
      sync2_q <= sync1_q; // R14
    end
  end

  assign {
    s_supply_low_lockout,
    s_en1,
    s_en2,
    s_torch,
    s_strobe,
    s_ovp,
    s_cap,
    s_therm,
    s_short,
    s_ilim,
    s_vf
  } = sync2_q;

  // lockout acts like power-on reset for all state below
  logic clear_all;
  assign clear_all = reset | s_supply_low_lockout; // R11

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] mode_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic       rd_flags;
  logic       wr_mode;
  logic       disabled;
  logic       timeout_hit;
  logic       startup_q;
  logic       two_pin_clear;

  // register_mode is a static strap, so it is used without synchronising
  assign rd_flags = register_mode & reg_rd & (reg_addr == ADDR_FAULT_FLAGS);
  // the fault flags are read only, so only the mode register takes writes
  assign wr_mode  = reg_wr & (reg_addr == ADDR_OUTPUT_MODE_CONTROL);

  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      mode_q <= RST_OUTPUT_MODE_CONTROL; // R11
    end else if (wr_mode) begin
      mode_q <= reg_wdata;
    end
  end

  // ****************************************************************
  // event start detection
  // ****************************************************************
  logic strobe_active;
  logic strobe_prev_q;
  logic strobe_edge;
  logic detect_on;
  logic run_req;
  logic run_prev_q;
  logic run_start;

  // an edge strobe makes a single-cycle request on its rising edge only
  assign strobe_edge   = s_strobe & ~strobe_prev_q;
  assign strobe_active = mode_q[MODE_STROBE_EN] &
                         (mode_q[MODE_STROBE_LVL] ? s_strobe : strobe_edge); // R13

  // register mode: the mode field or the strobe pin; two-pin mode: any enable input
  always_comb begin
    if (register_mode) begin
      run_req = (mode_q[MODE_OUT_LSB +: 2] != 2'b00) | strobe_active;
    end else begin
      run_req = s_en1 | s_en2 | s_torch;
    end
  end

  assign run_start = run_req & ~run_prev_q;
  assign detect_on = register_mode & mode_q[MODE_DETECT_EN]; // R9
  // two-pin mode has no register port, so dropping every enable input is the clear
  assign two_pin_clear = ~register_mode & ~s_en1 & ~s_en2 & ~s_torch; // R4

  // while disabled the start detector stays re-armed, so a cleared fault starts afresh
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      strobe_prev_q <= 1'b0;
      run_prev_q    <= 1'b0;
      startup_q     <= 1'b0;
    end else begin
      strobe_prev_q <= s_strobe;
      run_prev_q    <= run_req & ~disabled;
      startup_q     <= run_start & ~disabled;
    end
  end

  // ****************************************************************
  // fault flag latch
  // ****************************************************************
  // faults set regardless of a same-cycle read, so set wins over the clear
  always_comb begin
    flags_d = flags_q;
    if (rd_flags || two_pin_clear) begin
      flags_d = flags_q & ~FLAG_LATCH_MASK; // R12
    end
    if (s_ovp) begin
      flags_d[FLAG_OVP] = 1'b1; // R1 R3
    end
    if (s_cap && run_start) begin
      flags_d[FLAG_OVP] = 1'b1; // R2 R3
    end
    if (s_therm) begin
      flags_d[FLAG_THERMAL] = 1'b1; // R6
    end
    if (s_short && startup_q) begin
      flags_d[FLAG_SHORT] = 1'b1; // R7
    end
    if (s_ilim) begin
      flags_d[FLAG_ILIM] = 1'b1; // R8
    end
    if (timeout_hit) begin
      flags_d[FLAG_TIMEOUT] = 1'b1; // R4 R5
    end
    if (detect_on && startup_q) begin
      flags_d[FLAG_TWO_LEDS] = s_vf; // R10
    end
  end

  // lockout loads the flag reset value just like a power-on reset
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      flags_q <= RST_FAULT_FLAGS; // R11
    end else begin
      flags_q <= flags_d;
    end
  end

  assign disabled = has_fault(flags_q); // R12

  // ****************************************************************
  // 850 ms timeout from a divided tick
  // ****************************************************************
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int CW = $clog2(TIMEOUT_TICKS + 2);
  logic [TW-1:0] div_q;
  logic          tick;
  logic [CW-1:0] to_cnt_q;
  logic          to_cond;

  assign tick    = (div_q == TW'(TICK_CYCLES - 1));
  // in register mode only a level strobe can time out; an edge strobe is a single-cycle request
  always_comb begin
    if (register_mode) begin
      to_cond = mode_q[MODE_STROBE_EN] & mode_q[MODE_STROBE_LVL] & s_strobe; // R5
    end else begin
      to_cond = s_en1 & s_en2; // R4
    end
  end

  // the divider runs free, so the first tick may land up to one tick period early
  always_ff @(posedge clk_sys) begin
    if (clear_all || tick) begin
      div_q <= '0; // R15
    end else begin
      div_q <= div_q + TW'(1);
    end
  end

  // longer than the limit: fire once the count passes the limit tick
  always_ff @(posedge clk_sys) begin
    if (clear_all || !to_cond) begin
      to_cnt_q <= '0; // R15
    end else if (tick && to_cnt_q <= CW'(TIMEOUT_TICKS)) begin
      to_cnt_q <= to_cnt_q + CW'(1);
    end
  end

  assign timeout_hit = to_cond & tick & (to_cnt_q == CW'(TIMEOUT_TICKS)); // R4 R5

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_view(reg_addr, mode_q, flags_q);
      end
    end
  end

  // ****************************************************************
  // driver outputs
  // ****************************************************************
  // driver_enable drops on the same edge that latches the fault, not a cycle later
  always_ff @(posedge clk_sys) begin
    if (clear_all) begin
      driver_enable <= 1'b0;
      event_active  <= 1'b0;
      detect_drive  <= 1'b0;
      ilim_select   <= RST_OUTPUT_MODE_CONTROL[MODE_ILIM_LSB +: 2];
    end else begin
      driver_enable <= ~disabled & ~has_fault(flags_d); // R1 R6 R8
      event_active  <= run_req & ~disabled;
      detect_drive  <= detect_on & run_start & ~disabled; // R9
      ilim_select   <= mode_q[MODE_ILIM_LSB +: 2]; // R8
    end
  end
endmodule : ffl_fault_latch

`default_nettype wire

// ===== ffl_fault_latch_sva.sv
// port checker of the fault latch
`default_nettype none
module ffl_fault_latch_sva #(
  parameter int TICK_CYCLES   = 4,
  parameter int TIMEOUT_TICKS = 5
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       supply_low_lockout,
  input wire logic       register_mode,
  input wire logic       enable_input_one,
  input wire logic       enable_input_two,
  input wire logic       ovp_trip,
  input wire logic       thermal_trip,
  input wire logic       ilim_trip,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid,
  input wire logic       driver_enable,
  input wire logic [1:0] ilim_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // margin covers sync stages and the phase of the divided tick
  localparam int PinLimit = (TIMEOUT_TICKS + 2) * TICK_CYCLES + 6;
  logic [4:0] quiet_q;
  int         both_q;
  always_ff @(posedge clk_sys) quiet_q <= {quiet_q[3:0], reset | supply_low_lockout};
  always_ff @(posedge clk_sys) begin
    if (reset || register_mode || !(enable_input_one && enable_input_two)) both_q <= 0;
    else if (both_q < PinLimit) both_q <= both_q + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || supply_low_lockout);
  a_read_answer: assert property (reg_rd && quiet_q == 5'h00 |=> reg_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_ovp_off: assert property ($rose(ovp_trip) |-> ##3 !driver_enable)
    else $error("overvoltage did not disable");
  a_heat_off: assert property ($rose(thermal_trip) |-> ##3 !driver_enable)
    else $error("thermal did not disable");
  a_ilim_off: assert property ($rose(ilim_trip) |-> ##3 !driver_enable)
    else $error("current limit did not disable");
  a_latched_off: assert property (quiet_q == 5'h00 && register_mode && !driver_enable
    && !reg_rvalid |=> !driver_enable) else $error("re-enabled without read");
  a_ilim_mirror: assert property (reg_wr && reg_addr == 8'h04
    |-> ##2 ilim_select == $past(reg_wdata[7:6], 2)) else $error("limit select wrong");
  a_pin_timeout: assert property (both_q == PinLimit |-> !driver_enable)
    else $error("two-pin timeout missed");
endmodule : ffl_fault_latch_sva
`default_nettype wire

// ===== ffl_host.sv
// host model on the strobe register port
`default_nettype none
module ffl_host (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1;
    {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : ffl_host
`default_nettype wire

// ===== ffl_pkg.sv
// package of constants for the flash driver fault latch
// ****************************************************************
// Functional notes
// R1: overvoltage trip shuts down, sets flag bit 7, latches disabled until cleared.
// R2: missing output capacitor at event enable shuts down, sets bit 7, latches.
// R3: overvoltage and missing capacitor share the single flag bit 7.
// R4: two-pin mode, both enables high over 850 ms disables; all enables low clears.
// R5: register mode, strobe enabled and level sensitive, high over 850 ms sets bit 4.
// R6: thermal protection asserts: shut down, set bit 5, latch disabled.
// R7: lamp drive below short threshold during startup sets bit 6, latches.
// R8: current limit from mode bits 7:6; exceeding sets bit 1, latches disabled.
// R9: mode bit 3 enables LED count detection at 80 mA at each event start.
// R10: detection enabled and forward voltage above 4.3 V reads flag bit 3 high.
// R11: supply low lockout shuts down and resets every register to default.
// R12: host read of fault flags clears latched flags and re-enables the device.
// R13: mode bit 5 selects strobe edge (0) or level (1), level by default.
// R14: comparator and enable inputs are synchronised before latching or timing.
// R15: timeout counter restarts when condition drops, timed from a divided tick.
// ****************************************************************
`default_nettype none

package ffl_pkg;
  localparam logic [7:0] ADDR_OUTPUT_MODE_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_FAULT_FLAGS         = 8'h05;

  localparam logic [7:0] RST_OUTPUT_MODE_CONTROL  = 8'hB4;
  localparam logic [7:0] RST_FAULT_FLAGS          = 8'h08;

  localparam int MODE_ILIM_LSB   = 6;
  localparam int MODE_STROBE_LVL = 5;
  localparam int MODE_TORCH_OK   = 4;
  localparam int MODE_DETECT_EN  = 3;
  localparam int MODE_STROBE_EN  = 2;
  localparam int MODE_OUT_LSB    = 0;

  localparam int FLAG_OVP        = 7;
  localparam int FLAG_SHORT      = 6;
  localparam int FLAG_THERMAL    = 5;
  localparam int FLAG_TIMEOUT    = 4;
  localparam int FLAG_TWO_LEDS   = 3;
  localparam int FLAG_ILIM       = 1;

  localparam logic [7:0] FLAG_LATCH_MASK = 8'hF2;
  // reserved bits 2 and 0 always read as zero
  localparam logic [7:0] FLAG_READ_MASK  = 8'hFA;

  localparam int CLK_HZ          = 125_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TIMEOUT_MS      = 850;
  localparam int TIMEOUT_TICKS   = TIMEOUT_MS * 1000 / TICK_US;
  localparam int SYNC_STAGES     = 2;
endpackage : ffl_pkg

`default_nettype wire

// ===== tb_flash_driver_fault_latch.sv
// self-checking bench of the fault latch
`default_nettype none
module tb_flash_driver_fault_latch;
  timeunit 1ns;
  timeprecision 100ps;
  import ffl_pkg::*;
  typedef struct {logic [4:0] flt; logic stb; int hold; logic [7:0] exp;} ffl_row_t;
  logic       clk_sys = 1'b0, reset, supply_low_lockout, register_mode, torch_input;
  logic       enable_input_one, enable_input_two, strobe_input, ovp_trip, cap_missing;
  logic       thermal_trip, lamp_short, ilim_trip, vf_high, reg_wr, reg_rd, reg_rvalid;
  logic       driver_enable, event_active, detect_drive;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic [1:0] ilim_select;
  int         bad_count, n_tests, det_n;
  // fault order: overvoltage, capacitor, thermal, short, current limit
  ffl_row_t   rows [6] = '{'{5'h10, 0, 8, 8'h88}, '{5'h08, 1, 8, 8'h88}, '{5'h04, 0, 8, 8'h28},
                           '{5'h02, 1, 8, 8'h48}, '{5'h01, 0, 8, 8'h0A}, '{5'h00, 1, 60, 8'h18}};
  always #4 clk_sys = ~clk_sys;
  ffl_fault_latch #(.TICK_CYCLES(4), .TIMEOUT_TICKS(5)) i_ffl_fault_latch (.clk_sys, .reset,
    .supply_low_lockout, .register_mode, .enable_input_one, .enable_input_two, .torch_input,
    .strobe_input, .ovp_trip, .cap_missing, .thermal_trip, .lamp_short, .ilim_trip, .vf_high,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .driver_enable,
    .event_active, .detect_drive, .ilim_select);
  ffl_host i_ffl_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid);
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic strobe_count(input logic vf, input logic [7:0] exp);
    {vf_high, strobe_input, det_n} = {vf, 1'b1, 32'd0};
    repeat (6) begin
      step(1);
      det_n += int'(detect_drive);
    end
    chk({7'h00, event_active}, 8'h01);
    strobe_input = 1'b0;
    chk(8'(det_n != 0), 8'h01);
    i_ffl_host.rd(ADDR_FAULT_FLAGS, got);
    chk(got, exp);
  endtask : strobe_count
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {reset, register_mode, supply_low_lockout, torch_input, enable_input_one} = 5'b11000;
    {enable_input_two, strobe_input, ovp_trip, cap_missing, thermal_trip} = 5'b00000;
    {lamp_short, ilim_trip, vf_high} = 3'b000;
    step(20);
    reset = 1'b0;
    i_ffl_host.rd(ADDR_OUTPUT_MODE_CONTROL, got);
    chk(got, 8'hB4);
    i_ffl_host.wr(ADDR_FAULT_FLAGS, 8'hFF);
    i_ffl_host.rd(ADDR_FAULT_FLAGS, got);
    chk(got, 8'h08);
    i_ffl_host.rd(8'h07, got);
    chk(got, 8'h00);
    i_ffl_host.wr(ADDR_OUTPUT_MODE_CONTROL, 8'h37);
    step(3);
    chk({6'h00, ilim_select}, 8'h00);
    // standby output mode, so only the rows with stb set start an event, from the strobe pin
    i_ffl_host.wr(ADDR_OUTPUT_MODE_CONTROL, 8'hB4);
    foreach (rows[i]) begin
      {ovp_trip, cap_missing, thermal_trip, lamp_short, ilim_trip} = rows[i].flt;
      strobe_input = rows[i].stb;
      step(rows[i].hold);
      {ovp_trip, cap_missing, thermal_trip, lamp_short, ilim_trip, strobe_input} = 6'h00;
      step(4);
      chk({7'h00, driver_enable}, 8'h00);
      i_ffl_host.rd(ADDR_FAULT_FLAGS, got);
      chk(got, rows[i].exp);
      step(3);
      chk({7'h00, driver_enable}, 8'h01);
      $display("row %0d done", i);
    end
    i_ffl_host.wr(ADDR_OUTPUT_MODE_CONTROL, 8'hBC);
    strobe_count(1'b0, 8'h00);
    strobe_count(1'b1, 8'h08);
    $display("detection done");
    i_ffl_host.wr(ADDR_OUTPUT_MODE_CONTROL, 8'h94);
    strobe_input = 1'b1;
    step(60);
    chk({6'h00, event_active, driver_enable}, 8'h01);
    strobe_input = 1'b0;
    i_ffl_host.rd(ADDR_FAULT_FLAGS, got);
    chk(got, 8'h08);
    $display("edge strobe done");
    supply_low_lockout = 1'b1;
    step(5);
    chk({7'h00, driver_enable}, 8'h00);
    supply_low_lockout = 1'b0;
    step(5);
    i_ffl_host.rd(ADDR_OUTPUT_MODE_CONTROL, got);
    chk(got, 8'hB4);
    $display("lockout done");
    {register_mode, enable_input_one, enable_input_two} = 3'b011;
    step(60);
    chk({7'h00, driver_enable}, 8'h00);
    {enable_input_one, enable_input_two, torch_input} = 3'b001;
    step(4);
    chk({7'h00, driver_enable}, 8'h00);
    torch_input = 1'b0;
    step(4);
    chk({7'h00, driver_enable}, 8'h01);
    $display("two-pin done");
    tally_and_finish();
  end
endmodule : tb_flash_driver_fault_latch
bind ffl_fault_latch ffl_fault_latch_sva #(.TICK_CYCLES(TICK_CYCLES),
  .TIMEOUT_TICKS(TIMEOUT_TICKS)) i_sva (.clk_sys, .reset, .supply_low_lockout, .register_mode,
  .enable_input_one, .enable_input_two, .ovp_trip, .thermal_trip, .ilim_trip, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .driver_enable, .ilim_select);
`default_nettype wire
